/* File: pfs_program_flow_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE1: Jump always loads the counter from value, ignoring type and motor.
// RULE2: Call pushes the counter, then loads the subroutine address.
// RULE3: The return stack holds eight entries at most.
// RULE4: A call with a full stack is ignored entirely; the code still sets the overflow interrupt status bit.
// RULE5: Return pops the last saved address into the counter.
// RULE6: A return with an empty stack is ignored.
// RULE7: Wait decodes ticks, position, home switch, end switch, homing done.
// RULE8: Tick wait stalls for value ticks of ten milliseconds each.
// RULE9: Position wait stalls until reached; value is timeout, zero disables.
// RULE10: Switch and homing waits stall for the event with optional timeout.
// RULE11: A value of minus one takes the accumulator instead.
// RULE12: Software keeps the accumulator non-negative for such waits.
// RULE13: Expired timeout sets the timeout flag and moves on.
// RULE14: The counter stays on the wait until condition or timeout.
// RULE15: Flow instructions come only from a stored running program.
// RULE16: Conditional jump code eight tests the timeout flag.
// RULE17: Clear-error can clear only the timeout flag.
// RULE18: Frames hold address, opcode, type, motor, value, then checksum.
module pfs_program_flow_sequencer #(
    parameter int PC_WIDTH = 16,
    parameter int STACK_DEPTH_P = pfs_pkg::STACK_DEPTH,
    parameter int MOTORS = 1,
    parameter int TICK_CYCLES_P = pfs_pkg::TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire pfs_pkg::pfs_apb_req_t i_apb,
    output pfs_pkg::pfs_apb_rsp_t o_apb,
    output logic o_irq,
    output logic [PC_WIDTH-1:0] o_fetch_addr,
    output logic o_fetch_req,
    input wire logic i_fetch_valid,
    input wire pfs_pkg::pfs_instr_t i_instr,
    input wire pfs_pkg::pfs_motor_t [MOTORS-1:0] i_motor,
    input wire logic [31:0] i_accu,
    output logic o_timeout_error_flag,
    output logic o_checksum_error,
    output logic o_waiting
);
    import pfs_pkg::*;

    typedef enum {
        PFS_IDLE,
        PFS_FETCH,
        PFS_WAIT
    } pfs_state_t;

    pfs_state_t state;
    logic [PC_WIDTH-1:0] pc;
    logic [31:0] ctrl;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;

    logic [31:0] tick_div;
    logic [31:0] tick_left;
    logic tick_pulse;

    logic [7:0] wait_kind;
    logic [7:0] wait_motor;
    logic timeout_on;

    logic stack_full;
    logic stack_empty;
    logic [PC_WIDTH-1:0] stack_top;

    logic push;
    logic pop;
    logic take;
    logic sum_ok;
    logic [7:0] sum;
    logic [31:0] eff_value;

    logic cond_met;
    logic wait_done;
    logic wait_timeout;

    logic wr_en;
    logic rd_en;
    logic [31:0] rd_data;

    logic ev_timeout;
    logic ev_overflow;
    logic ev_done;

    logic [2:0] irq_clear;
    pfs_motor_t sel_motor;

    // A frame with a bad checksum is dropped and the counter stays put.
    assign sum = i_instr.address + i_instr.opcode + i_instr.kind
        + i_instr.motor + i_instr.value[31:24] + i_instr.value[23:16]
        + i_instr.value[15:8] + i_instr.value[7:0]; // [RULE18]
    assign sum_ok = (sum == i_instr.checksum); // [RULE18]
    assign take = o_fetch_req && i_fetch_valid;

    // Negative accumulator values are the program's fault; used as is.
    assign eff_value = (i_instr.value == VALUE_FROM_ACCU) ? i_accu
        : i_instr.value; // [RULE11] [RULE12]

    // Call and return touch the stack only for a frame that passed its check.
    assign push = i_ce && take && sum_ok
        && i_instr.opcode == OP_CALL_SUBROUTINE && !stack_full; // [RULE4]
    assign pop = i_ce && take && sum_ok
        && i_instr.opcode == OP_RETURN_FROM_SUBROUTINE
        && !stack_empty; // [RULE6]

    pfs_return_stack #(
        .DEPTH(STACK_DEPTH_P),
        .WIDTH(PC_WIDTH)
    ) u_stack (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_push(push),
        .i_pop(pop),
        .i_data(pc + 1'b1),
        .o_top(stack_top),
        .o_full(stack_full),
        .o_empty(stack_empty)
    ); // [RULE3]

    // Motor numbers beyond the fitted axes read as idle, so a wait on one
    // can only end through its timeout.
    always_comb begin
        sel_motor = '0;
        for (int m = 0; m < MOTORS; m++) begin
            if (wait_motor == 8'(m)) begin
                sel_motor = i_motor[m];
            end
        end
    end

    // An unknown wait type ends at once rather than hanging the program.
    always_comb begin
        case (wait_kind) // [RULE7]
            WAIT_TICKS: cond_met = (tick_left == '0); // [RULE8]
            WAIT_POSITION: cond_met = sel_motor.position_reached; // [RULE9]
            WAIT_HOME_SWITCH: cond_met = sel_motor.home_switch; // [RULE10]
            WAIT_END_SWITCH: cond_met = sel_motor.end_switch; // [RULE10]
            WAIT_HOMING_DONE: cond_met = sel_motor.homing_done; // [RULE10]
            default: cond_met = 1'b1;
        endcase
    end

    assign wait_done = (state == PFS_WAIT) && cond_met;
    // A tick wait has no timeout of its own: it ends when the count runs out.
    assign wait_timeout = (state == PFS_WAIT) && !cond_met && timeout_on
        && tick_left == '0 && wait_kind != WAIT_TICKS; // [RULE13]

    assign tick_pulse = (tick_div == 32'(TICK_CYCLES_P - 1));

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tick_div <= '0;
        end else if (i_ce) begin
            if (state != PFS_WAIT || tick_pulse) begin
                tick_div <= '0;
            end else begin
                tick_div <= tick_div + 1'b1;
            end
        end
    end

    // The tick time base restarts with each wait, so the first tick is
    // always a full ten milliseconds rather than a partial one.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tick_left <= '0;
            wait_kind <= '0;
            wait_motor <= '0;
            timeout_on <= 1'b0;
        end else if (i_ce) begin
            if (take && sum_ok && i_instr.opcode == OP_WAIT) begin
                tick_left <= eff_value; // [RULE8] [RULE11]
                wait_kind <= i_instr.kind;
                wait_motor <= i_instr.motor;
                timeout_on <= (eff_value != '0); // [RULE9]
            end else if (state == PFS_WAIT && tick_pulse
                    && tick_left != '0) begin
                tick_left <= tick_left - 1'b1;
            end
        end
    end

    // The counter moves only on a checked frame, so a rejected frame is
    // simply fetched again from the same address.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= PFS_IDLE;
            pc <= '0;
        end else if (i_ce) begin
            case (state)
                PFS_IDLE: begin
                    if (ctrl[CTRL_RUN_BIT]) begin // [RULE15]
                        state <= PFS_FETCH;
                    end
                end
                PFS_FETCH: begin
                    if (!ctrl[CTRL_RUN_BIT]) begin
                        state <= PFS_IDLE;
                    end else if (take && sum_ok) begin
                        case (i_instr.opcode)
                            OP_JUMP_ALWAYS: begin
                                pc <= i_instr.value[PC_WIDTH-1:0]; // [RULE1]
                            end
                            OP_CALL_SUBROUTINE: begin
                                if (!stack_full) begin
                                    pc <= i_instr.value[PC_WIDTH-1:0]; // [RULE2]
                                end else begin
                                    pc <= pc + 1'b1; // [RULE4]
                                end
                            end
                            OP_RETURN_FROM_SUBROUTINE: begin
                                if (!stack_empty) begin
                                    pc <= stack_top; // [RULE5]
                                end else begin
                                    pc <= pc + 1'b1; // [RULE6]
                                end
                            end
                            OP_JUMP_CONDITIONAL: begin
                                if (i_instr.kind == COND_TIMEOUT
                                        && o_timeout_error_flag) begin
                                    pc <= i_instr.value[PC_WIDTH-1:0]; // [RULE16]
                                end else begin
                                    pc <= pc + 1'b1;
                                end
                            end
                            OP_WAIT: begin
                                state <= PFS_WAIT; // [RULE14]
                            end
                            default: begin
                                pc <= pc + 1'b1;
                            end
                        endcase
                    end
                end
                PFS_WAIT: begin
                    if (wait_done || wait_timeout) begin
                        pc <= pc + 1'b1; // [RULE13] [RULE14]
                        state <= PFS_FETCH;
                    end
                end
                default: begin
                    state <= PFS_IDLE;
                end
            endcase
        end
    end

    // A fresh timeout wins over a clear in the same cycle.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_timeout_error_flag <= 1'b0;
        end else if (i_ce) begin
            if (wait_timeout) begin
                o_timeout_error_flag <= 1'b1; // [RULE13]
            end else if (take && sum_ok && i_instr.opcode == OP_CLEAR_ERROR
                    && (i_instr.kind == CLEAR_ALL
                    || i_instr.kind == CLEAR_TIMEOUT)) begin
                o_timeout_error_flag <= 1'b0; // [RULE17]
            end
        end
    end

    // One pulse per rejected frame lets software count them.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_checksum_error <= 1'b0;
        end else if (i_ce) begin
            o_checksum_error <= take && !sum_ok; // [RULE18]
        end
    end

    assign o_fetch_addr = pc;
    // Clearing the run bit stops fetching at once, leaving the stack intact.
    assign o_fetch_req = (state == PFS_FETCH) && ctrl[CTRL_RUN_BIT];
    assign o_waiting = (state == PFS_WAIT);

    assign ev_timeout = wait_timeout;
    // A call refused for lack of stack space is otherwise silent.
    assign ev_overflow = push == 1'b0 && i_ce && take && sum_ok
        && i_instr.opcode == OP_CALL_SUBROUTINE;
    assign ev_done = wait_done;

    // Registers answer with no wait states.
    assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;
    assign rd_en = i_apb.psel && !i_apb.pwrite;
    assign irq_clear = (wr_en && i_apb.paddr == REG_IRQ_STATUS)
        ? i_apb.pwdata[2:0] : 3'h0;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl <= RESET_CTRL;
            irq_mask <= RESET_IRQ_MASK;
        end else if (i_ce && wr_en) begin
            if (i_apb.paddr == REG_CTRL) begin
                ctrl <= {31'h0, i_apb.pwdata[CTRL_RUN_BIT]};
            end
            if (i_apb.paddr == REG_IRQ_MASK) begin
                irq_mask <= i_apb.pwdata[2:0];
            end
        end
    end

    // Set has priority over write-one-to-clear.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_status <= '0;
        end else if (i_ce) begin
            irq_status <= (irq_status & ~irq_clear)
                | {ev_done, ev_overflow, ev_timeout};
        end
    end

    assign o_irq = |(irq_status & irq_mask);

    // Read data are taken in the setup cycle and stand through the access.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_data <= '0;
        end else if (i_ce && rd_en && !i_apb.penable) begin
            case (i_apb.paddr)
                REG_CTRL: rd_data <= ctrl;
                REG_STATUS: rd_data <= {28'h0, o_checksum_error,
                    stack_full, o_waiting, o_timeout_error_flag};
                REG_IRQ_STATUS: rd_data <= {29'h0, irq_status};
                REG_IRQ_MASK: rd_data <= {29'h0, irq_mask};
                REG_PC: rd_data <= 32'(pc);
                REG_ACCU: rd_data <= i_accu;
                default: rd_data <= '0;
            endcase
        end
    end

    // The response is driven as one word so that it has a single driver.
    assign o_apb = {1'b1, i_apb.psel && i_apb.penable
        && i_apb.paddr > REG_ACCU, rd_data};
endmodule // pfs_program_flow_sequencer

/* File: pfs_pkg.sv */
package pfs_pkg;

    localparam logic [7:0] OP_JUMP_CONDITIONAL = 8'h15;
    localparam logic [7:0] OP_JUMP_ALWAYS = 8'h16;
    localparam logic [7:0] OP_CALL_SUBROUTINE = 8'h17;
    localparam logic [7:0] OP_RETURN_FROM_SUBROUTINE = 8'h18;
    localparam logic [7:0] OP_CLEAR_ERROR = 8'h1c;
    localparam logic [7:0] OP_WAIT = 8'h1b;

    localparam logic [7:0] WAIT_TICKS = 8'h00;
    localparam logic [7:0] WAIT_POSITION = 8'h01;
    localparam logic [7:0] WAIT_HOME_SWITCH = 8'h02;
    localparam logic [7:0] WAIT_END_SWITCH = 8'h03;
    localparam logic [7:0] WAIT_HOMING_DONE = 8'h04;

    localparam logic [7:0] COND_TIMEOUT = 8'h08;
    localparam logic [7:0] CLEAR_ALL = 8'h00;
    localparam logic [7:0] CLEAR_TIMEOUT = 8'h01;

    localparam logic [31:0] VALUE_FROM_ACCU = 32'hffffffff;
    localparam int STACK_DEPTH = 8;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;

    localparam logic [31:0] REG_CTRL = 32'h00;
    localparam logic [31:0] REG_STATUS = 32'h04;
    localparam logic [31:0] REG_IRQ_STATUS = 32'h08;
    localparam logic [31:0] REG_IRQ_MASK = 32'h0c;
    localparam logic [31:0] REG_PC = 32'h10;
    localparam logic [31:0] REG_ACCU = 32'h14;
    localparam int CTRL_RUN_BIT = 0;
    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_OVERFLOW_BIT = 1;
    localparam int IRQ_WAIT_DONE_BIT = 2;
    localparam logic [31:0] RESET_CTRL = 32'h0;
    localparam logic [2:0] RESET_IRQ_MASK = 3'h0;

    typedef struct packed {
        logic [7:0] address;
        logic [7:0] opcode;
        logic [7:0] kind;
        logic [7:0] motor;
        logic [31:0] value;
        logic [7:0] checksum;
    } pfs_instr_t;

    typedef struct packed {
        logic position_reached;
        logic home_switch;
        logic end_switch;
        logic homing_done;
    } pfs_motor_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } pfs_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pfs_apb_rsp_t;

endpackage

/* File: pfs_return_stack.sv */
`timescale 1ns/1ps
module pfs_return_stack #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 16
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [WIDTH-1:0] i_data,
    output logic [WIDTH-1:0] o_top,
    output logic o_full,
    output logic o_empty
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [$clog2(DEPTH+1)-1:0] count;

    assign o_full = (count == ($clog2(DEPTH+1))'(DEPTH));
    assign o_empty = (count == '0);
    assign o_top = o_empty ? '0 : mem[($clog2(DEPTH))'(count - 1'b1)];

    // Full and empty guards make an ignored call or return leave no trace.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count <= '0;
        end else if (i_ce) begin
            if (i_push && !o_full) begin
                count <= count + 1'b1;
            end else if (i_pop && !o_empty) begin
                count <= count - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce && i_push && !o_full) begin
            mem[count[$clog2(DEPTH)-1:0]] <= i_data;
        end
    end
endmodule // pfs_return_stack

/* File: pfs_flow_assertions.sv */
`timescale 1ns/1ps
module pfs_flow_assertions #(
    parameter int PC_WIDTH = 16,
    parameter int STACK_DEPTH_P = 8,
    parameter int MOTORS = 1,
    parameter int TICK_CYCLES_P = 10
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic [PC_WIDTH-1:0] o_fetch_addr,
    input wire logic o_fetch_req,
    input wire logic i_fetch_valid,
    input wire pfs_pkg::pfs_instr_t i_instr,
    input wire pfs_pkg::pfs_motor_t [MOTORS-1:0] i_motor,
    input wire logic [31:0] i_accu,
    input wire logic o_timeout_error_flag,
    input wire logic o_checksum_error,
    input wire logic o_waiting
);
    import pfs_pkg::*;
    logic tk, ok, go, tick, hit;
    logic [7:0] sum, op, wk;
    logic [3:0] depth, mb;
    logic [31:0] cnt, len;
    logic [PC_WIDTH-1:0] val;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    assign op = i_instr.opcode;
    assign tk = o_fetch_req & i_fetch_valid & i_ce;
    assign sum = i_instr.address + op + i_instr.kind + i_instr.motor
        + i_instr.value[31:24] + i_instr.value[23:16]
        + i_instr.value[15:8] + i_instr.value[7:0];
    assign ok = sum == i_instr.checksum;
    assign go = tk & ok;
    assign mb = i_motor[0];
    assign hit = wk inside {[8'h1:8'h4]} && mb[2'(8'h4 - wk)];
    // Shadow depth lets the call and return checks know full and empty.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            depth <= '0;
        end else if (go && op == OP_CALL_SUBROUTINE
                && depth < 4'(STACK_DEPTH_P)) begin
            depth <= depth + 4'h1;
        end else if (go && op == OP_RETURN_FROM_SUBROUTINE
                && depth != 4'h0) begin
            depth <= depth - 4'h1;
        end
    end
    always_ff @(posedge i_clk) begin
        val <= i_instr.value[PC_WIDTH-1:0];
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt <= '0;
            len <= '0;
            tick <= 1'b0;
            wk <= '0;
        end else if (go && op == OP_WAIT) begin
            cnt <= '0;
            len <= (i_instr.value == VALUE_FROM_ACCU ? i_accu
                : i_instr.value) * 32'(TICK_CYCLES_P);
            tick <= i_instr.kind == WAIT_TICKS;
            wk <= i_instr.kind;
        end else if (o_waiting) begin
            cnt <= cnt + 32'h1;
        end
    end
    AST_JUMP: assert property (
        go && op == OP_JUMP_ALWAYS |=> o_fetch_addr == val)
        else $error("jump target not taken");
    AST_CALL: assert property (
        go && op == OP_CALL_SUBROUTINE && depth < 4'(STACK_DEPTH_P)
        |=> o_fetch_addr == val)
        else $error("call target not taken");
    AST_CALL_FULL: assert property (
        go && op == OP_CALL_SUBROUTINE && depth == 4'(STACK_DEPTH_P)
        |=> o_fetch_addr == $past(o_fetch_addr) + 1'b1)
        else $error("call on full stack not ignored");
    AST_RET_EMPTY: assert property (
        go && op == OP_RETURN_FROM_SUBROUTINE && depth == 4'h0
        |=> o_fetch_addr == $past(o_fetch_addr) + 1'b1)
        else $error("return on empty stack not ignored");
    AST_WAIT_ENTER: assert property (
        go && op == OP_WAIT && i_instr.kind <= WAIT_HOMING_DONE
        && i_instr.value != 32'h0 |=> o_waiting && $stable(o_fetch_addr))
        else $error("wait not entered");
    AST_WAIT_HOLD: assert property (
        o_waiting && $past(o_waiting) |-> $stable(o_fetch_addr) && !o_fetch_req)
        else $error("counter moved during wait");
    AST_TICK_LEN: assert property (
        tick && $fell(o_waiting) |-> cnt + 32'h1 >= len && cnt <= len + 32'h1)
        else $error("tick wait length wrong");
    AST_EVENT: assert property (
        o_waiting && hit |-> ##[1:2] !o_waiting)
        else $error("event did not end wait");
    AST_TIMEOUT: assert property (
        $rose(o_timeout_error_flag) |-> $fell(o_waiting))
        else $error("timeout flag without wait end");
    AST_JC: assert property (
        go && op == OP_JUMP_CONDITIONAL && i_instr.kind == COND_TIMEOUT
        && o_timeout_error_flag |=> o_fetch_addr == val)
        else $error("timeout branch not taken");
    AST_CHECKSUM: assert property (
        tk && !ok |=> o_checksum_error && $stable(o_fetch_addr))
        else $error("bad frame not rejected");
    C_FULL: cover property (go && op == OP_CALL_SUBROUTINE && depth == 4'h8);
    C_TIMEOUT: cover property ($rose(o_timeout_error_flag));
    C_EVENT: cover property (o_waiting && hit);
endmodule // pfs_flow_assertions

/* File: pfs_program_store.sv */
`timescale 1ns/1ps
module pfs_program_store (
    input wire logic i_clk,
    input wire logic i_fetch_req,
    input wire logic [15:0] i_fetch_addr,
    input wire logic i_stall,
    output logic o_fetch_valid,
    output pfs_pkg::pfs_instr_t o_instr
);
    import pfs_pkg::*;
    pfs_instr_t mem [0:255];
    pfs_instr_t noise = {9{8'h5a}};
    logic [15:0] bad_addr;
    assign o_fetch_valid = i_fetch_req & ~i_stall;
    // Idle word lines toggle so a stale frame can never look valid.
    always_comb begin
        o_instr = noise;
        if (o_fetch_valid) begin
            o_instr = mem[i_fetch_addr[7:0]];
            if (i_fetch_addr == bad_addr) begin
                o_instr.checksum = ~o_instr.checksum;
            end
        end
    end
    always @(posedge i_clk) begin
        noise <= ~noise;
        if (o_fetch_valid && i_fetch_addr == bad_addr) begin
            bad_addr <= 16'hffff;
        end
    end
endmodule // pfs_program_store

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import pfs_pkg::*;
    logic i_clk, i_nrst, i_ce, i_fetch_valid, stall;
    logic o_irq, o_fetch_req, o_timeout_error_flag, o_checksum_error;
    logic o_waiting;
    logic [15:0] o_fetch_addr;
    logic [31:0] i_accu;
    pfs_apb_req_t i_apb;
    pfs_apb_rsp_t o_apb;
    pfs_instr_t i_instr;
    pfs_motor_t [0:0] i_motor;
    integer seed = 32'h88c7;
    int fail_count = 0;
    int checks = 0;
    int bad_frames = 0;
    logic [15:0] exp_pc [$];
    logic [32:0] exp_rd [$];
    pfs_program_flow_sequencer #(.TICK_CYCLES_P(10))
        i_pfs_program_flow_sequencer (.i_clk, .i_nrst, .i_ce, .i_apb,
        .o_apb, .o_irq, .o_fetch_addr, .o_fetch_req, .i_fetch_valid,
        .i_instr, .i_motor, .i_accu, .o_timeout_error_flag,
        .o_checksum_error, .o_waiting);
    pfs_program_store i_pfs_program_store (.i_clk, .i_fetch_req(o_fetch_req),
        .i_fetch_addr(o_fetch_addr), .i_stall(stall),
        .o_fetch_valid(i_fetch_valid), .o_instr(i_instr));
    task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic fail_wait(input string n);
        fail_count++;
        $display("ERROR %s wait expected done seen hang", n);
        end_of_test();
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
            input logic [32:0] e);
        int n;
        n = 0;
        if (!w) begin
            exp_rd.push_back(e);
        end
        i_apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_clk);
        i_apb.penable <= 1'b1;
        @(posedge i_clk);
        while (o_apb.pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_wait("apb");
            end
            @(posedge i_clk);
        end
        i_apb <= '0;
        @(posedge i_clk);
    endtask
    task automatic put(input int a, input logic [7:0] op, input logic [7:0] k,
            input logic [31:0] v);
        pfs_instr_t f;
        f = {8'h01, op, k, 8'h00, v, 8'h00};
        f.checksum = f.address + op + k + v[31:24] + v[23:16] + v[15:8] + v[7:0];
        i_pfs_program_store.mem[a] = f;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (exp_pc.size() > 0) begin
            n++;
            if (n > 1000) begin
                fail_wait("fetch");
            end
            @(posedge i_clk);
        end
    endtask
    task automatic chk_irq(input logic e);
        @(posedge i_clk);
        chk("irq", o_irq, e);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // The accumulator stays small and positive, as programs must keep it.
    always @(posedge i_clk) begin
        stall <= ($random(seed) & 3) == 0;
        i_accu <= {30'h0, 2'($random(seed))} + 32'h1;
        if (o_checksum_error === 1'b1) begin
            bad_frames++;
        end
        if (o_fetch_req && i_fetch_valid && exp_pc.size() > 0) begin
            chk("pc", o_fetch_addr, exp_pc.pop_front());
        end
        if (i_apb.psel && i_apb.penable && !i_apb.pwrite && o_apb.pready) begin
            chk("prdata", {o_apb.pslverr, o_apb.prdata}, exp_rd.pop_front());
        end
    end
    initial begin
        i_nrst = 1'b0;
        i_ce = 1'b1;
        i_apb = '0;
        i_motor = '0;
        i_accu = 32'h1;
        stall = 1'b0;
        i_pfs_program_store.bad_addr = 16'd5;
        put(0, OP_JUMP_ALWAYS, 8'h5a, 5);
        put(5, OP_CALL_SUBROUTINE, 0, 20);
        put(20, OP_RETURN_FROM_SUBROUTINE, 0, 0);
        put(6, OP_RETURN_FROM_SUBROUTINE, 0, 0);
        put(7, OP_WAIT, WAIT_TICKS, 3);
        put(8, OP_WAIT, WAIT_POSITION, 2);
        put(9, OP_JUMP_CONDITIONAL, COND_TIMEOUT, 30);
        put(30, OP_CLEAR_ERROR, CLEAR_TIMEOUT, 0);
        put(31, OP_WAIT, WAIT_HOME_SWITCH, 0);
        for (int i = 32; i < 41; i++) begin
            put(i, OP_CALL_SUBROUTINE, 0, i < 40 ? i + 1 : 60);
        end
        put(41, OP_RETURN_FROM_SUBROUTINE, 0, 0);
        put(60, OP_WAIT, WAIT_HOMING_DONE, VALUE_FROM_ACCU);
        put(61, OP_WAIT, WAIT_END_SWITCH, 0);
        put(62, OP_WAIT, WAIT_TICKS, VALUE_FROM_ACCU);
        put(63, OP_JUMP_ALWAYS, 0, 63);
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        apb(1, REG_PC, 32'h55, 0);
        for (int a = 0; a <= 16; a += 4) begin
            apb(0, a, 0, 33'h0);
        end
        apb(0, 32'h20, 0, {1'b1, 32'h0});
        apb(1, REG_IRQ_MASK, 32'h7, 0);
        exp_pc = {16'd0, 16'd5, 16'd5, 16'd20, 16'd6, 16'd7, 16'd8, 16'd9,
            16'd30, 16'd31};
        apb(1, REG_CTRL, 32'h1, 0);
        drain();
        apb(0, REG_IRQ_STATUS, 0, 33'h5);
        apb(0, REG_STATUS, 0, 33'h2);
        chk("waiting", o_waiting, 1);
        chk("timeout flag", o_timeout_error_flag, 0);
        apb(1, REG_IRQ_STATUS, 32'h5, 0);
        apb(0, REG_IRQ_STATUS, 0, 33'h0);
        chk_irq(1'b0);
        for (int i = 32; i <= 41; i++) begin
            exp_pc.push_back(16'(i));
        end
        exp_pc = {exp_pc, 16'd40, 16'd60, 16'd61, 16'd62, 16'd63, 16'd63};
        i_motor <= 4'b0110;
        drain();
        chk("timeout flag", o_timeout_error_flag, 1);
        apb(0, REG_STATUS, 0, 33'h5);
        apb(0, REG_PC, 0, 33'h3f);
        apb(0, REG_IRQ_STATUS, 0, 33'h7);
        apb(1, REG_IRQ_MASK, 32'h2, 0);
        chk_irq(1'b1);
        apb(1, REG_IRQ_MASK, 32'h0, 0);
        chk_irq(1'b0);
        apb(1, REG_IRQ_STATUS, 32'h7, 0);
        apb(1, REG_IRQ_MASK, 32'h7, 0);
        chk_irq(1'b0);
        chk("bad frames", bad_frames, 1);
        chk("reads left", exp_rd.size(), 0);
        end_of_test();
    end
endmodule // tb
bind pfs_program_flow_sequencer pfs_flow_assertions #(.PC_WIDTH(PC_WIDTH),
    .STACK_DEPTH_P(STACK_DEPTH_P), .MOTORS(MOTORS),
    .TICK_CYCLES_P(TICK_CYCLES_P)) i_pfs_flow_assertions (.i_clk, .i_nrst,
    .i_ce, .o_fetch_addr, .o_fetch_req, .i_fetch_valid, .i_instr, .i_motor,
    .i_accu, .o_timeout_error_flag, .o_checksum_error, .o_waiting);
